// file: shared/rkas_pkg.sv
package rkas_pkg;

	// 25 MHz block clock
	localparam int unsigned CLK_HZ       = 25_000_000;
	localparam int unsigned CLK_KHZ      = CLK_HZ / 1000;

	// wake-up blanking after standby, microseconds
	localparam int unsigned WAKE_TIME_US = 500;
	localparam int unsigned WAKE_CYC     =
		(WAKE_TIME_US * CLK_KHZ + 999) / 1000;

	// inactivity timeout, inside the 300..500 ms window
	localparam int unsigned IDLE_MIN_MS  = 300;
	localparam int unsigned IDLE_MAX_MS  = 500;
	localparam int unsigned IDLE_TIME_MS = 400;
	localparam int unsigned IDLE_CYC     = IDLE_TIME_MS * CLK_KHZ;

	// reference clock half period in block clocks
	localparam int unsigned REF_HALF_CYC = 16;

	// carrier synthesizer multiplier
	localparam int unsigned PLL_MULT     = 32;

	localparam int unsigned IDLE_W = 24;
	localparam int unsigned WAKE_W = 14;
	localparam int unsigned REF_W  = 8;
	localparam int unsigned XTAL_W = 16;
	localparam int unsigned RF_W   = 21;

	// gray order along standby -> wake -> active
	typedef enum logic [1:0] {
		RKAS_STANDBY = 2'b00,
		RKAS_WAKE    = 2'b01,
		RKAS_ACTIVE  = 2'b11
	} rkas_mode_t;

endpackage : rkas_pkg

// file: rtl/rkas_buf.sv
`timescale 1ns/1ps
`default_nettype none

module rkas_buf
	import rkas_pkg::*;
#(
	parameter int unsigned W = 1
)(
	input  wire logic         clock_in,
	input  wire logic         rst_in,
	input  wire logic         in_valid_in,
	input  wire logic [W-1:0] in_data_in,
	output logic              in_ready_out,
	output logic              out_valid_out,
	output logic [W-1:0]      out_data_out,
	input  wire logic         out_ready_in
);

	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic [1:0]        cnt;
		logic              wp;
		logic              rp;
		logic              rdy;
	} rkas_buf_t;

	rkas_buf_t s_r;
	rkas_buf_t s_nxt;
	logic      push;
	logic      pop;

	assign push          = in_valid_in && s_r.rdy;
	assign pop           = out_ready_in && (s_r.cnt != 2'h0);
	assign in_ready_out  = s_r.rdy;
	assign out_valid_out = s_r.cnt != 2'h0;
	assign out_data_out  = s_r.mem[s_r.rp];

	always_comb
	begin
		s_nxt = s_r;
		if (push)
		begin
			s_nxt.mem[s_r.wp] = in_data_in;
			s_nxt.wp          = ~s_r.wp;
		end
		if (pop)
			s_nxt.rp = ~s_r.rp;
		if (push && !pop)
			s_nxt.cnt = s_r.cnt + 2'h1;
		else if (pop && !push)
			s_nxt.cnt = s_r.cnt - 2'h1;
		// registered ready: refuses the cycle after the second word lands
		s_nxt.rdy = s_nxt.cnt != 2'h2;
	end

	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
			s_r <= '{mem: '0, cnt: 2'h0, wp: 1'b0, rp: 1'b0, rdy: 1'b1};
		else
			s_r <= s_nxt;
	end

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);

	no_overflow_a: assert property (s_r.cnt != 2'h3)
		else $error("buffer count above two");
	full_refuses_a: assert property (s_r.cnt == 2'h2 |-> !in_ready_out)
		else $error("full buffer still accepting");

endmodule : rkas_buf

`default_nettype wire

// file: rtl/rkas_top.sv
`timescale 1ns/1ps
`default_nettype none

module rkas_top
	import rkas_pkg::*;
#(
	parameter int unsigned IDLE_CYCLES = IDLE_CYC,
	parameter int unsigned WAKE_CYCLES = WAKE_CYC
)(
	input  wire logic              clock_in,
	input  wire logic              rst_in,
	input  wire logic              keying_output_line_in,
	input  wire logic              rf_ready_in,
	input  wire logic [XTAL_W-1:0] xtal_khz_in,
	output logic                   key_accept_out,
	output logic                   carrier_out,
	output logic                   pll_on_out,
	output logic                   standby_out,
	output logic                   reference_clock_output_out,
	output logic [RF_W-1:0]        rf_freq_khz_out
);

	localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(IDLE_CYCLES - 1);
	localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(WAKE_CYCLES - 1);
	localparam logic [REF_W-1:0]  REF_LAST  = REF_W'(REF_HALF_CYC - 1);
	localparam logic [RF_W-1:0]   MULT      = RF_W'(PLL_MULT);

	typedef struct packed {
		logic              sync1;
		logic              sync2;
		logic              key_prev;
		rkas_mode_t        mode;
		logic [IDLE_W-1:0] idle_cnt;
		logic [WAKE_W-1:0] wake_cnt;
		logic [REF_W-1:0]  ref_cnt;
		logic              ref_clk;
		logic              applied;
		logic              carrier;
		logic              pll_on;
		logic [RF_W-1:0]   rf_freq;
		logic              pend;
		logic              standby;
	} rkas_state_t;

	rkas_state_t s_r;
	rkas_state_t s_nxt;

	logic key_edge;
	logic key_rise;
	logic buf_valid;
	logic buf_data;
	logic buf_ready;
	logic buf_in_ready;
	logic buf_push;

	assign key_edge = s_r.sync2 ^ s_r.key_prev;
	// a transition refused by a full buffer waits here, so the latest
	// level still reaches the modulator once the stall clears
	assign buf_push = key_edge || s_r.pend;
	assign key_rise = s_r.sync2 && !s_r.key_prev;
	// queued levels drain only once the synthesizer has settled
	assign buf_ready = (s_r.mode == RKAS_ACTIVE) && rf_ready_in;

	rkas_buf #(
		.W (1)
	) u_buf (
		.clock_in      (clock_in),
		.rst_in        (rst_in),
		.in_valid_in   (buf_push),
		.in_data_in    (s_r.sync2),
		.in_ready_out  (buf_in_ready),
		.out_valid_out (buf_valid),
		.out_data_out  (buf_data),
		.out_ready_in  (buf_ready)
	);

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.sync1    = keying_output_line_in;
		s_nxt.sync2    = s_r.sync1;
		s_nxt.key_prev = s_r.sync2;

		if (key_edge)
			s_nxt.idle_cnt = '0;
		else if (s_r.idle_cnt != IDLE_LAST)
			s_nxt.idle_cnt = s_r.idle_cnt + IDLE_W'(1);

		if (buf_valid && buf_ready)
			s_nxt.applied = buf_data;
		s_nxt.pend = buf_push && !buf_in_ready;

		case (s_r.mode)
			RKAS_STANDBY:
			begin
				if (key_rise)
				begin
					s_nxt.mode     = RKAS_WAKE;
					s_nxt.pll_on   = 1'b1;
					s_nxt.wake_cnt = '0;
				end
			end
			RKAS_WAKE:
			begin
				if (s_r.wake_cnt == WAKE_LAST)
					s_nxt.mode = RKAS_ACTIVE;
				else
					s_nxt.wake_cnt = s_r.wake_cnt + WAKE_W'(1);
			end
			RKAS_ACTIVE:
			begin
				if (!key_edge && s_r.idle_cnt == IDLE_LAST)
				begin
					s_nxt.mode    = RKAS_STANDBY;
					s_nxt.pll_on  = 1'b0;
					s_nxt.applied = 1'b0;
				end
			end
			default:
			begin
				s_nxt.mode   = RKAS_STANDBY;
				s_nxt.pll_on = 1'b0;
			end
		endcase
		s_nxt.standby = s_nxt.mode == RKAS_STANDBY;

		// carrier follows the drained level, only when fully awake
		s_nxt.carrier = s_nxt.applied
			&& (s_nxt.mode == RKAS_ACTIVE);

		if (s_nxt.carrier)
		begin
			if (s_r.ref_cnt == REF_LAST)
			begin
				s_nxt.ref_cnt = '0;
				s_nxt.ref_clk = ~s_r.ref_clk;
			end
			else
				s_nxt.ref_cnt = s_r.ref_cnt + REF_W'(1);
		end
		else
		begin
			// parked low so the controller sees no stray edges
			s_nxt.ref_cnt = '0;
			s_nxt.ref_clk = 1'b0;
		end

		// frequency only meaningful while the loop runs
		if (s_nxt.pll_on)
			s_nxt.rf_freq = RF_W'(xtal_khz_in) * MULT;
		else
			s_nxt.rf_freq = '0;
	end

	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
			s_r <= '{sync1: 1'b0, sync2: 1'b0, key_prev: 1'b0,
				mode: RKAS_STANDBY, idle_cnt: '0, wake_cnt: '0,
				ref_cnt: '0, ref_clk: 1'b0, applied: 1'b0,
				carrier: 1'b0, pll_on: 1'b0, rf_freq: '0, pend: 1'b0,
				standby: 1'b1};
		else
			s_r <= s_nxt;
	end

	assign key_accept_out             = buf_in_ready;
	assign carrier_out                = s_r.carrier;
	assign pll_on_out                 = s_r.pll_on;
	assign standby_out                = s_r.standby;
	assign reference_clock_output_out = s_r.ref_clk;
	assign rf_freq_khz_out            = s_r.rf_freq;

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);

	sequence wake_done_s;
		s_r.mode == RKAS_WAKE && s_r.wake_cnt == WAKE_LAST;
	endsequence

	sequence idle_expiry_s;
		s_r.mode == RKAS_ACTIVE && !key_edge && s_r.idle_cnt == IDLE_LAST;
	endsequence

	key_path_a: assert property (
		s_r.sync2 == $past(keying_output_line_in, 2))
		else $error("keying line not two stages behind pin");
	carrier_level_a: assert property (
		carrier_out |-> s_r.applied && s_r.mode == RKAS_ACTIVE)
		else $error("carrier on without high keying level");
	level_track_a: assert property (
		s_r.mode == RKAS_ACTIVE && !buf_valid && !s_r.pend
			|-> s_r.applied == s_r.key_prev)
		else $error("carrier level lost a keying transition");
	wake_delay_a: assert property (
		wake_done_s |=> s_r.mode == RKAS_ACTIVE)
		else $error("wake delay did not end in active mode");
	wake_hold_a: assert property (
		$rose(s_r.mode == RKAS_WAKE) |-> s_r.wake_cnt == '0 && !carrier_out)
		else $error("wake sequence entered wrongly");
	ref_only_tx_a: assert property (
		$rose(reference_clock_output_out) |-> $past(carrier_out) && carrier_out)
		else $error("reference clock toggled while not transmitting");
	idle_timeout_a: assert property (
		idle_expiry_s |=> standby_out && !pll_on_out)
		else $error("idle timeout did not enter standby");
	standby_off_a: assert property (
		standby_out |-> !pll_on_out && !carrier_out)
		else $error("RF or PLL on during standby");
	ref_low_a: assert property (
		standby_out |-> !reference_clock_output_out)
		else $error("reference clock not low in standby");
	freq_mult_a: assert property (
		pll_on_out |-> rf_freq_khz_out == RF_W'($past(xtal_khz_in)) * MULT)
		else $error("carrier not 32 times crystal");
	edge_restart_a: assert property (
		key_edge |=> s_r.idle_cnt == '0)
		else $error("keying transition did not restart idle timer");
	rise_wakes_a: assert property (
		standby_out && key_rise |=> s_r.mode == RKAS_WAKE && pll_on_out)
		else $error("rising edge in standby did not wake");

endmodule : rkas_top

`default_nettype wire

// file: tb/rkas_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

module rkas_ctrl_model
(
	input  wire logic clock_in,
	input  wire logic level_in,
	input  wire logic sleep_in,
	input  wire logic stall_in,
	input  wire logic ref_clk_in,
	output logic      keying_output_line_out,
	output logic      rf_ready_out,
	output logic      ref_seen_out
);
	logic ref_seen_r;

	// ref pin is only ever read, never driven back
	always_ff @(posedge clock_in) ref_seen_r <= ref_clk_in;
	// driven from time zero; forced low before sleep so standby can follow
	assign keying_output_line_out = level_in & ~sleep_in;
	// every model output is driven, none left floating
	assign rf_ready_out           = ~stall_in;
	// reference as the controller's calibration input samples it
	assign ref_seen_out           = ref_seen_r;
endmodule // rkas_ctrl_model

`default_nettype wire

// file: tb/rkas_top_bench.sv
`timescale 1ns/1ps
`default_nettype none

module rkas_top_bench;
	import rkas_pkg::*;
	localparam int IDLE = 200;
	localparam int WAKE = 20;
	logic              clock_in = 1'b0;
	logic              rst_in   = 1'b1;
	logic              level    = 1'b0;
	logic              sleep    = 1'b0;
	logic              stall    = 1'b0;
	logic [XTAL_W-1:0] xtal     = '0;
	logic [16:0]       seed     = 17'h15375;
	logic              key_line, rf_ready, accept, carrier;
	logic              pll_on, standby, ref_clk, ref_seen;
	logic [RF_W-1:0]   rf_freq;
	int                mismatches = 0;
	int                compares   = 0;
	int                cycles     = 0;

	rkas_ctrl_model model (.clock_in(clock_in), .level_in(level),
		.sleep_in(sleep), .stall_in(stall), .ref_clk_in(ref_clk),
		.keying_output_line_out(key_line), .rf_ready_out(rf_ready),
		.ref_seen_out(ref_seen));
	rkas_top #(.IDLE_CYCLES(IDLE), .WAKE_CYCLES(WAKE)) dut (
		.clock_in(clock_in), .rst_in(rst_in),
		.keying_output_line_in(key_line), .rf_ready_in(rf_ready),
		.xtal_khz_in(xtal), .key_accept_out(accept),
		.carrier_out(carrier), .pll_on_out(pll_on),
		.standby_out(standby), .reference_clock_output_out(ref_clk),
		.rf_freq_khz_out(rf_freq));

	always #20 clock_in = ~clock_in;

	function automatic logic [16:0] lfsr(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction

	function automatic logic [RF_W-1:0] freq_of(input logic [XTAL_W-1:0] x);
		return RF_W'(x) * RF_W'(PLL_MULT);
	endfunction

	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD %s expected %0h seen %0h", what, e, g);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask

	task automatic idle_state();
		chk("standby", 1, standby);
		chk("pll_on", 0, pll_on);
		chk("carrier", 0, carrier);
		chk("rf_freq", 0, rf_freq);
		chk("ref_clk", 0, ref_clk);
	endtask

	always @(posedge clock_in)
	begin
		cycles++;
		if (cycles > 5000)
		begin
			mismatches++;
			conclude();
		end
	end

	initial
	begin
		int n;
		int r;
		logic first;
		step(3);
		rst_in = 1'b0;
		idle_state();
		chk("accept", 1, accept);
		$display("reset test done");
		seed = lfsr(seed);
		xtal = seed[15:0];
		level = 1'b1;
		step(4);
		chk("pll_on", 1, pll_on);
		chk("carrier_blank", 0, carrier);
		chk("rf_freq", freq_of(xtal), rf_freq);
		n = 0;
		while (carrier !== 1'b1 && n < WAKE + 10)
		begin
			step(1);
			n++;
		end
		chk("wake_delay", 1, n >= WAKE - 2 && n <= WAKE + 2);
		r = 0;
		repeat (80)
		begin
			step(1);
			r += (ref_seen === 1'b1);
		end
		chk("ref_running", 1, r > 20 && r < 60);
		$display("wake test done");
		for (int i = 0; i < 8; i++)
		begin
			seed = lfsr(seed);
			level = ~level;
			step(6 + seed[3:0]);
			chk("carrier", level, carrier);
			chk("ref_idle", 0, ref_clk & ~level);
		end
		$display("keying test done");
		first = level;
		stall = 1'b1;
		repeat (3)
		begin
			level = ~level;
			step(5);
		end
		chk("accept_full", 0, accept);
		chk("carrier_held", first, carrier);
		stall = 1'b0;
		step(8);
		chk("carrier_catchup", level, carrier);
		level = ~level;
		step(8);
		chk("carrier_sync", level, carrier);
		$display("stall test done");
		level = 1'b0;
		step(8);
		level = 1'b1;
		step(IDLE - 40);
		chk("standby_early", 0, standby);
		chk("carrier_on", 1, carrier);
		step(60);
		idle_state();
		$display("idle test done");
		sleep = 1'b1;
		step(10);
		chk("key_line", 0, key_line);
		idle_state();
		sleep = 1'b0;
		step(4);
		chk("pll_rewake", 1, pll_on);
		$display("sleep test done");
		conclude();
	end
endmodule // rkas_top_bench

`default_nettype wire
